/* rtl/csc_pkg.sv */
// How it works
// [RULE1] Mode bit picks end or empty interrupt.
// [RULE2] End mode interrupts after last bit shifted.
// [RULE3] Empty mode interrupts when word leaves buffer.
// [RULE4] Active flag shows a transfer in progress.
// [RULE5] Buffer flag shows unconsumed written data.
// [RULE6] Overrun flag sets on error, else zero.
// [RULE7] Data register low byte carries data.
// [RULE8] Prescaler and upper seven bits divide clock.
// [RULE9] Four-bit prescale field per clock source.
// [RULE10] Software writes operation mode bits as zero.
// [RULE11] Mask bit gates the error interrupt.
// [RULE12] No chip select; software uses port pins.
// [RULE13] Unit works only when enable bit set.
// [RULE14] Bit order: zero MSB first, one LSB.
// [RULE15] Transmit and receive enables pick direction.
// [RULE16] Receive-only master writes all-ones dummy data.
// [RULE17] Polarity and phase bits pick four timings.
// [RULE18] Master drives clock, shifts, samples opposite edges.
// [RULE19] Overrun when new word lands before read.
`default_nettype none
package csc_pkg;
  // ************************************************************
  // Register byte addresses.
  // ************************************************************
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_COMM = 8'h08;
  localparam logic [7:0] A_FLAG = 8'h0C;
  localparam logic [7:0] A_TRIG = 8'h10;
  localparam logic [7:0] A_PRS = 8'h14;
  localparam logic [7:0] A_PER = 8'h18;
  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int F_DIV = 9;
  localparam int F_ISS = 0;
  localparam int F_CCS = 14;
  localparam int F_CKS = 15;
  localparam int F_DIR = 7;
  localparam int F_EOC = 10;
  localparam int F_CKP = 12;
  localparam int F_DAP = 13;
  localparam int F_RXE = 14;
  localparam int F_TXE = 15;
  localparam int F_OVF = 0;
  localparam int F_BFF = 5;
  localparam int F_TSF = 6;
  localparam int F_START = 0;
  localparam int F_STOP = 1;
  localparam int F_EN = 0;
  // ************************************************************
  // Writable masks and reset values.
  // ************************************************************
  localparam logic [15:0] MODE_MASK = 16'hC007;
  localparam logic [15:0] COMM_MASK = 16'hF480;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] COMM_RST = 16'hC000;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [7:0] PRS_RST = 8'h00;
  // ************************************************************
  // Frame and buffer sizes.
  // ************************************************************
  localparam int BITS = 8;
  localparam logic [3:0] LAST_HALF = 4'(2 * BITS - 1);
  localparam int FIFO_DEPTH = 32;
  typedef enum logic {ST_IDLE, ST_SHIFT} csc_state_t;
endpackage
`default_nettype wire

/* rtl/csc_fifo.sv */
`default_nettype none
module csc_fifo import csc_pkg::*; #(
  parameter int W = 8, // Word width.
  parameter int D = 32 // Depth in words.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic flush, // Empties the buffer.
  input wire logic [W-1:0] in_data, // Word to store.
  input wire logic in_valid, // Store request.
  output logic in_ready, // Room for a word.
  output logic [W-1:0] out_data, // Oldest word.
  output logic out_valid, // A word is held.
  input wire logic out_ready // Consumer takes it.
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  // Pointers wrap by hand so that depths other than powers of two work.
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? ((wp == AW'(D - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp = pop ? ((rp == AW'(D - 1)) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
    end
  end

  // Storage has no reset; only the count decides what is valid.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  assign in_ready = (cnt != (AW+1)'(D)) && !flush;
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
endmodule
`default_nettype wire

/* rtl/csc_clkdiv.sv */
`default_nettype none
module csc_clkdiv import csc_pkg::*; (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic run, // Counts while high.
  input wire logic [3:0] prs, // Divide by two to this power.
  input wire logic [6:0] div, // Further divide, minus one.
  output logic tick // One pulse per serial half period.
);
  logic [14:0] pre, next_pre;
  logic [6:0] cnt, next_cnt;
  logic next_tick, pre_end;

  // Prescaler first, then the channel divider on its wrap.
  always_comb begin
    pre_end = (pre == 15'((16'h0001 << prs) - 16'h0001));
    next_pre = pre_end ? '0 : pre + 15'h0001;
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_pre = '0;
      next_cnt = '0;
    end else if (pre_end) begin
      if (cnt == div) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      pre <= next_pre;
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* rtl/csc_channel.sv */
`default_nettype none
module csc_channel import csc_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH // Transmit buffer depth.
) (
  input wire logic pclk, // Bus clock, 50 MHz.
  input wire logic presetn, // Async reset, active low.
  input wire logic [7:0] paddr, // Byte address.
  input wire logic psel, // Slave select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Write when high.
  input wire logic [31:0] pwdata, // Write data.
  output logic [31:0] prdata, // Read data.
  output logic pready, // Transfer done.
  output logic pslverr, // Unmapped address.
  output logic serial_clock_pin, // Serial clock out.
  output logic serial_out_pin, // Serial data out.
  input wire logic serial_in_pin, // Serial data in.
  output logic transfer_irq, // Transfer interrupt pulse.
  output logic error_irq // Error interrupt pulse.
);
  // ************************************************************
  // Declarations.
  // ************************************************************
  csc_state_t state, next_state;
  logic [15:0] mode_q, comm_q, next_mode, next_comm, flag_word;
  logic [6:0] div_q, next_div;
  logic [7:0] prs_q, next_prs, rx_data, next_rx_data;
  logic [7:0] txs, rxs, next_txs, next_rxs;
  logic [3:0] half, next_half, prs_sel;
  logic unit_en, running, ovf, rx_valid;
  logic next_unit_en, next_running, next_ovf, next_rx_valid;
  logic sck, next_sck, so, next_so, si_m, si_s;
  logic next_tirq, next_eirq;
  logic [31:0] next_prdata, rd_word;
  logic next_pready, next_pslverr, addr_ok;
  logic acc, wr, rd_clr, busy, load, done, tick, ovf_set;
  logic smp, shf, iss, dir, ckp, dap, txe, rxe, eoc;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;

  // Bit that goes on the wire next, by the selected order.
  function automatic logic out_bit(input logic [7:0] d,
                                   input logic lsb_first);
    out_bit = lsb_first ? d[0] : d[7];
  endfunction

  // Moves the sending word on by one bit.
  function automatic logic [7:0] shift_word(input logic [7:0] d,
                                            input logic lsb_first,
                                            input logic b);
    shift_word = lsb_first ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  assign iss = mode_q[F_ISS]; // RULE1
  assign dir = comm_q[F_DIR];
  assign ckp = comm_q[F_CKP];
  assign dap = comm_q[F_DAP];
  assign txe = comm_q[F_TXE];
  assign rxe = comm_q[F_RXE];
  assign eoc = comm_q[F_EOC];
  assign busy = (state == ST_SHIFT);

  // ************************************************************
  // APB slave.
  // ************************************************************
  // The answer is registered, so a data write into a full buffer
  // simply holds pready low until a word drains.
  always_comb begin
    acc = psel && penable;
    wr = acc && pready && pwrite && !pslverr;
    rd_clr = acc && pready && !pwrite && (paddr == A_DATA);
    flag_word = 16'h0000;
    flag_word[F_TSF] = busy; // RULE4
    flag_word[F_BFF] = fifo_out_valid; // RULE5
    flag_word[F_OVF] = ovf; // RULE6
    addr_ok = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      A_DATA: rd_word = {16'h0000, div_q, 1'b0, rx_data}; // RULE7
      A_MODE: rd_word = {16'h0000, mode_q};
      A_COMM: rd_word = {16'h0000, comm_q};
      A_FLAG: rd_word = {16'h0000, flag_word};
      A_TRIG: rd_word = {31'h00000000, running};
      A_PRS: rd_word = {24'h000000, prs_q};
      A_PER: rd_word = {31'h00000000, unit_en};
      default: addr_ok = 1'b0;
    endcase
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (acc && !pready &&
        !(pwrite && paddr == A_DATA && unit_en && !fifo_in_ready)) begin
      next_pready = 1'b1;
      next_pslverr = !addr_ok;
      next_prdata = pwrite ? 32'h00000000 : rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // Control registers.
  // ************************************************************
  // Only the enable register accepts writes while the unit is off.
  always_comb begin
    next_unit_en = unit_en;
    next_mode = mode_q;
    next_comm = comm_q;
    next_div = div_q;
    next_prs = prs_q;
    next_running = running;
    fifo_in_valid = wr && (paddr == A_DATA) && unit_en; // RULE7
    if (wr && paddr == A_PER) begin
      next_unit_en = pwdata[F_EN];
    end
    if (wr && unit_en) begin // RULE13
      unique case (paddr)
        A_DATA: next_div = pwdata[F_DIV+6:F_DIV]; // RULE8
        A_MODE: next_mode = pwdata[15:0] & MODE_MASK;
        A_COMM: next_comm = pwdata[15:0] & COMM_MASK;
        A_PRS: next_prs = pwdata[7:0]; // RULE9
        A_TRIG: begin
          if (pwdata[F_START]) begin
            next_running = 1'b1;
          end
          if (pwdata[F_STOP]) begin
            next_running = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (!unit_en) begin // RULE13
      next_running = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_en <= 1'b0;
      mode_q <= MODE_RST;
      comm_q <= COMM_RST;
      div_q <= DIV_RST;
      prs_q <= PRS_RST;
      running <= 1'b0;
    end else begin
      unit_en <= next_unit_en;
      mode_q <= next_mode;
      comm_q <= next_comm;
      div_q <= next_div;
      prs_q <= next_prs;
      running <= next_running;
    end
  end

  // ************************************************************
  // Transmit buffer and bit clock.
  // ************************************************************
  csc_fifo #(.W(8), .D(DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!unit_en),
    .in_data(pwdata[7:0]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  assign prs_sel = mode_q[F_CKS] ? prs_q[7:4] : prs_q[3:0]; // RULE8

  csc_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy),
    .prs(prs_sel),
    .div(div_q),
    .tick(tick)
  );

  // Serial input is asynchronous; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      si_m <= 1'b0;
      si_s <= 1'b0;
    end else begin
      si_m <= serial_in_pin;
      si_s <= si_m;
    end
  end

  // ************************************************************
  // Shift engine.
  // ************************************************************
  // Even half periods end at the leading clock edge. Phase bit zero
  // samples there and shifts on the trailing edge; phase bit one is
  // the reverse. Bit 0 is presented at load in both cases.
  always_comb begin
    next_state = state;
    next_txs = txs;
    next_rxs = rxs;
    next_half = half;
    next_sck = busy ? sck : ckp; // RULE17
    next_so = so;
    next_rx_data = rx_data;
    next_tirq = 1'b0;
    fifo_out_ready = 1'b0;
    load = !busy && running && unit_en && fifo_out_valid && // RULE13
           (txe || rxe); // RULE15
    smp = (half[0] == dap); // RULE17
    shf = !smp && (half != 4'h0) && (half != LAST_HALF);
    done = busy && tick && (half == LAST_HALF);
    if (load) begin
      next_state = ST_SHIFT;
      fifo_out_ready = 1'b1;
      next_txs = fifo_out_data;
      next_half = 4'h0;
      next_so = txe ? out_bit(fifo_out_data, dir) : 1'b1; // RULE14
      next_tirq = iss; // RULE3
    end else if (busy && tick) begin
      next_sck = !sck; // RULE18
      next_half = half + 4'h1;
      if (smp) begin
        next_rxs = shift_word(rxs, dir, si_s); // RULE18
      end
      if (shf) begin
        next_txs = shift_word(txs, dir, 1'b1);
        next_so = txe ? out_bit(next_txs, dir) : 1'b1; // RULE15
      end
      if (done) begin
        next_state = ST_IDLE;
        next_tirq = !iss; // RULE2
        if (rxe) begin
          next_rx_data = smp ? shift_word(rxs, dir, si_s) : rxs;
        end
      end
    end
    // The running bit lags the enable by a cycle, so both end a word.
    if (!(running && unit_en) && busy) begin // RULE13
      next_state = ST_IDLE;
      next_sck = ckp;
    end
  end

  // Received word and overrun; a new event wins over a clear.
  always_comb begin
    ovf_set = done && rxe && rx_valid && !rd_clr; // RULE19
    next_rx_valid = (done && rxe) || (rx_valid && !rd_clr);
    next_ovf = ovf_set || (ovf &&
               !(wr && unit_en && paddr == A_FLAG && pwdata[F_OVF])); // RULE6
    next_eirq = ovf_set && eoc; // RULE11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      txs <= 8'h00;
      rxs <= 8'h00;
      half <= 4'h0;
      sck <= 1'b0;
      so <= 1'b1;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      ovf <= 1'b0;
      transfer_irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      state <= next_state;
      txs <= next_txs;
      rxs <= next_rxs;
      half <= next_half;
      sck <= next_sck;
      so <= next_so;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      ovf <= next_ovf;
      transfer_irq <= next_tirq;
      error_irq <= next_eirq;
    end
  end

  assign serial_clock_pin = sck;
  assign serial_out_pin = so;

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load_empty;
    load && iss;
  endsequence
  sequence s_end_word;
    done && !iss && running;
  endsequence

  property p_irq_cause;
    transfer_irq |-> $past(load && iss) || $past(done && !iss);
  endproperty
  a_irq_cause: assert property (p_irq_cause) // RULE1
    else $error("transfer interrupt without its cause");

  property p_end_irq;
    s_end_word |=> transfer_irq && !busy;
  endproperty
  a_end_irq: assert property (p_end_irq) // RULE2
    else $error("end interrupt missing after last bit");

  property p_empty_irq;
    s_load_empty |=> transfer_irq && busy;
  endproperty
  a_empty_irq: assert property (p_empty_irq) // RULE3
    else $error("empty interrupt missing at load");

  property p_active;
    $rose(busy) |-> $past(load);
  endproperty
  a_active: assert property (p_active) // RULE4
    else $error("active flag rose without a load");

  property p_buffer;
    fifo_in_valid |=> fifo_out_valid || busy;
  endproperty
  a_buffer: assert property (p_buffer) // RULE5
    else $error("written word not shown as buffered");

  property p_overrun;
    ovf_set |=> ovf ##1 ovf;
  endproperty
  a_overrun: assert property (p_overrun) // RULE19
    else $error("overrun flag not held after overrun");

  property p_push;
    acc && pready && pwrite && paddr == A_DATA && unit_en
      |-> fifo_in_ready;
  endproperty
  a_push: assert property (p_push) // RULE7
    else $error("data write accepted with buffer full");

  property p_err_mask;
    ovf_set |=> error_irq == $past(eoc);
  endproperty
  a_err_mask: assert property (p_err_mask) // RULE11
    else $error("error interrupt not gated by mask");

  property p_idle_clock;
    $fell(busy) |-> serial_clock_pin == ckp;
  endproperty
  a_idle_clock: assert property (p_idle_clock) // RULE17
    else $error("serial clock not at idle level");

  property p_unit_off;
    !unit_en |=> !busy;
  endproperty
  a_unit_off: assert property (p_unit_off) // RULE13
    else $error("engine busy while unit disabled");
endmodule
`default_nettype wire

/* dv/csc_peer.sv */
`default_nettype none
// ************************************************************
// Far-side serial peripheral model.
// ************************************************************
module csc_peer (
  input wire logic sck, // Serial clock from the channel.
  input wire logic sdo, // Data from the channel.
  output logic sdi, // Data back to the channel.
  input wire logic ckp, // Idle level of the clock.
  input wire logic dap, // Phase select.
  input wire logic lsb, // Low bit first when high.
  input wire logic load, // Arms a new frame on its rising edge.
  input wire logic [7:0] tx, // Byte to send.
  output logic [7:0] got, // Last byte received.
  output var int frames // Count of bytes received.
);
  timeunit 1ns;
  timeprecision 1ns;
  int k = 0;
  int n = 0;
  logic [7:0] sh = 8'h00;

  // Bit k of the byte; outside a frame the line shows the inverse of its
  // last level, so a stale value can never pass for data.
  function automatic logic pick(input int i, input logic last);
    if (i < 0 || i > 7) return !last;
    return lsb ? tx[i] : tx[7 - i];
  endfunction

  initial begin
    sdi = 1'b1;
    got = 8'h00;
    frames = 0;
  end

  // Arming a frame; with phase 1 the first bit shows at the leading edge.
  always @(posedge load) begin
    k = dap ? -1 : 0;
    n = 0;
    sdi = pick(k, sdi);
  end

  // There is no select line, so framing is kept by counting edges alone.
  // Samples on one clock edge and shifts on the other one.
  always @(sck) begin
    if ((sck != ckp) ^ dap) begin
      sh = lsb ? {sdo, sh[7:1]} : {sh[6:0], sdo};
      n = n + 1;
      if (n == 8) begin
        got = sh;
        frames = frames + 1;
        n = 0;
        k = -1;
      end
    end else begin
      k = k + 1;
      sdi = pick(k, sdi);
    end
  end
endmodule
`default_nettype wire

/* dv/clocked_serial_channel_tb_top.sv */
`default_nettype none
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
  end \
end
module clocked_serial_channel_tb_top import csc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] comm; logic [7:0] tb, pb, erx, epe;} csc_row_t;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, transfer_irq, error_irq;
  logic serial_clock_pin, serial_out_pin, serial_in_pin;
  logic ckp = 1'b0, dap = 1'b0, lsb = 1'b0, load = 1'b0;
  logic [7:0] ptx = 8'h00, pgot;
  int pframes, nt, ne, f0;
  int n_errors = 0, check_count = 0, cyc = 0, t_last = 0, gap = 0;
  int n_tirq = 0, n_eirq = 0, irq_at = 0;
  // Enables, bit order, polarity and phase in every combination used.
  csc_row_t rows [7] = '{
    '{16'hC000, 8'hA5, 8'h3C, 8'h3C, 8'hA5},
    '{16'hC080, 8'h81, 8'h06, 8'h06, 8'h81},
    '{16'hD000, 8'h5A, 8'hC3, 8'hC3, 8'h5A},
    '{16'hE000, 8'h12, 8'h34, 8'h34, 8'h12},
    '{16'hF080, 8'h1E, 8'hE7, 8'hE7, 8'h1E},
    '{16'h8000, 8'h96, 8'h69, 8'h00, 8'h96},
    '{16'h4000, 8'hFF, 8'h4B, 8'h4B, 8'hFF}};

  // ************************************************************
  // Design and far side.
  // ************************************************************
  csc_channel #(.DEPTH(FIFO_DEPTH)) i_dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .serial_clock_pin, .serial_out_pin, .serial_in_pin, .transfer_irq,
    .error_irq);
  csc_peer i_peer (.sck(serial_clock_pin), .sdo(serial_out_pin),
    .sdi(serial_in_pin), .ckp, .dap, .lsb, .load, .tx(ptx), .got(pgot),
    .frames(pframes));

  // Clock at 50 MHz.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Pulse counters; irq_at notes how many bytes the peer had at the pulse.
  always @(posedge pclk) begin
    cyc++;
    if (transfer_irq === 1'b1) begin
      n_tirq++;
      irq_at = pframes;
    end
    if (error_irq === 1'b1) n_eirq++;
  end
  // Cycles between serial clock edges; the last one is a half period.
  always @(serial_clock_pin) begin
    gap = cyc - t_last;
    t_last = cyc;
  end

  // ************************************************************
  // Bus tasks.
  // ************************************************************
  // One transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9000);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 9000) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Data word with divider 1 in the upper bits.
  function automatic logic [31:0] dw(input logic [7:0] b);
    return {16'h0, 7'h01, 1'b0, b};
  endfunction
  // Polls the flags until the channel is idle and its buffer empty.
  task automatic wait_idle();
    int n = 0;
    do begin
      apb(1'b0, A_FLAG, 32'h0);
      n++;
    end while ((rdat[F_TSF] !== 1'b0 || rdat[F_BFF] !== 1'b0) && n < 3000);
    if (n >= 3000) n_errors++;
  endtask
  task automatic arm(input logic [15:0] c, input logic [7:0] b);
    ckp = c[F_CKP];
    dap = c[F_DAP];
    lsb = c[F_DIR];
    ptx = b;
    // A new idle level reaches the clock pin one edge after the write;
    // arming one edge later keeps that step out of the new frame.
    repeat (2) @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk) load <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The run should take about six thousand cycles.
  initial begin
    #(20 * 60000);
    n_errors++;
    end_of_test();
  end

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_COMM, 32'h1000);
    apb(1'b0, A_COMM, 32'h0);
    `CHK(rdat[15:0], COMM_RST)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    apb(1'b1, A_PER, 32'h1);
    apb(1'b1, A_PRS, 32'h12);
    apb(1'b1, A_TRIG, 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, A_COMM, {16'h0, rows[i].comm});
      arm(rows[i].comm, rows[i].pb);
      nt = n_tirq;
      apb(1'b1, A_DATA, dw(rows[i].tb));
      wait_idle();
      apb(1'b0, A_DATA, 32'h0);
      if (rows[i].comm[F_RXE]) `CHK(rdat[7:0], rows[i].erx)
      `CHK(pgot, rows[i].epe)
      `CHK(gap, 4 * 2)
      `CHK(irq_at, pframes)
      `CHK(n_tirq, nt + 1)
    end
    // Empty-buffer interrupt, second prescaler field, divider 2.
    apb(1'b1, A_MODE, 32'h8001);
    arm(16'hC000, 8'h00);
    f0 = pframes;
    nt = n_tirq;
    apb(1'b1, A_DATA, 32'h0455);
    wait_idle();
    `CHK(irq_at, f0)
    `CHK(n_tirq, nt + 1)
    `CHK(gap, 2 * 3)
    // Reading the word here keeps it from counting as an overrun below.
    apb(1'b0, A_DATA, 32'h0);
    `CHK(rdat[7:0], 8'h00)
    apb(1'b1, A_MODE, 32'h0);
    // Two words unread raise overrun; the mask then blocks the pulse.
    apb(1'b1, A_COMM, 32'hC400);
    arm(16'hC000, 8'h00);
    ne = n_eirq;
    apb(1'b1, A_DATA, dw(8'h11));
    apb(1'b1, A_DATA, dw(8'h22));
    wait_idle();
    `CHK(rdat[F_OVF], 1'b1)
    `CHK(n_eirq, ne + 1)
    apb(1'b1, A_FLAG, 32'h1);
    apb(1'b0, A_FLAG, 32'h0);
    `CHK(rdat[F_OVF], 1'b0)
    apb(1'b1, A_COMM, 32'hC000);
    apb(1'b1, A_DATA, dw(8'h33));
    wait_idle();
    `CHK(rdat[F_OVF], 1'b1)
    `CHK(n_eirq, ne + 1)
    apb(1'b1, A_FLAG, 32'h1);
    apb(1'b0, A_DATA, 32'h0);
    // Overfill the buffer in transmit-only mode; the first word loads at once, so no write stalls.
    apb(1'b1, A_COMM, 32'h8000);
    arm(16'h8000, 8'h00);
    f0 = pframes;
    for (int i = 0; i <= FIFO_DEPTH; i++) apb(1'b1, A_DATA, dw(8'(i)));
    apb(1'b0, A_FLAG, 32'h0);
    `CHK(rdat[F_BFF], 1'b1)
    wait_idle();
    `CHK(rdat[F_OVF], 1'b0)
    `CHK(pframes, f0 + FIFO_DEPTH + 1)
    `CHK(pgot, 8'(FIFO_DEPTH))
    // Stop in mid-word, then switch the unit off and try a write.
    apb(1'b1, A_COMM, 32'hC000);
    apb(1'b1, A_DATA, dw(8'hC3));
    apb(1'b1, A_TRIG, 32'h2);
    apb(1'b0, A_FLAG, 32'h0);
    `CHK(rdat[F_TSF], 1'b0)
    apb(1'b0, A_TRIG, 32'h0);
    `CHK(rdat[F_START], 1'b0)
    apb(1'b1, A_PER, 32'h0);
    apb(1'b1, A_DATA, dw(8'h01));
    apb(1'b0, A_FLAG, 32'h0);
    `CHK(rdat[F_BFF], 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
